// ---- src/hhu_host_uart.sv ----
/*
 * host facing four wire uart: serial receive and transmit with
 * request and clear to send, a receive and a transmit queue, and a
 * bit rate made from a divisor plus first and second half stuffing.
 * assumes cfg_in, cfg_load, boot_active and the byte streams come from
 * logic on the same clock; rxd and cts_n come from pins.
 */
// Summary of operation
// - four wires: rx, tx, rts, cts flow control
// - rates from 57600 bps to 6 Mbps
// - during boot cap rate near 750 kbps
// - separate 1040 byte receive and transmit queues
// - carries h4 packets as transparent byte stream
// - default rate is 115.2 kbaud
// - uart clock 24 mhz, selectable 48 mhz
// - divisor divides uart clock by 16 multiples
// - adjust stuffs up to eight first-half cycles
// - adjust stuffs up to eight end cycles
// - 24 mhz high rate for 3M, 2M
// - 48 mhz high rate for 6M, 4M
// - vendor command rewrites divisor and adjust
// - combined rate error within five percent
`include "hhu_params.svh"
`default_nettype none
module hhu_host_uart
    import hhu_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    input wire logic rxd,
    input wire logic cts_n,
    output logic txd,
    output logic rts_n,
    input wire logic boot_active,
    input wire logic cfg_load,
    input wire hhu_cfg_t cfg_in,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    output logic frame_err
);
    hhu_state_t s;
    hhu_state_t next_s;
    logic [12:0] base;
    logic [3:0] first_stuff;
    logic [3:0] end_stuff;
    logic [12:0] bit_len;
    logic [12:0] mid_at;
    logic [12:0] boot_min;
    logic [1:0] go;
    logic [1:0] mid;
    logic [1:0] fin;

    // queue index step with wrap at the last slot, shared by both queues
    function automatic logic [10:0] hhu_next_idx(input logic [10:0] idx);
        hhu_next_idx = (idx == `HHU_QIDX_LAST) ? 11'h000 : idx + 11'h001;
    endfunction

    function automatic logic [3:0] hhu_clamp_stuff(input logic [3:0] n);
        hhu_clamp_stuff = (n > `HHU_STUFF_MAX) ? `HHU_STUFF_MAX : n;
    endfunction

    // bit time: divisor times 16 in normal mode, divisor alone in high rate mode
    always_comb begin
        base = s.cfg.high_rate ? {5'h00, s.cfg.baud_divisor_reg}
                               : {1'b0, s.cfg.baud_divisor_reg, 4'h0};
        if (base < `HHU_MIN_BIT) begin
            base = `HHU_MIN_BIT;
        end
        first_stuff = hhu_clamp_stuff(s.cfg.baud_adjust_reg[7:4]);
        end_stuff = hhu_clamp_stuff(s.cfg.baud_adjust_reg[3:0]);
        bit_len = base + {9'h000, first_stuff} + {9'h000, end_stuff};
        mid_at = (base >> 1) + {9'h000, first_stuff};
        boot_min = s.cfg.uclk_fast ? `HHU_BOOT_BIT_FAST : `HHU_BOOT_BIT_SLOW;
        // while booting no bit is shorter than the capped rate allows
        if (boot_active && bit_len < boot_min) begin
            bit_len = boot_min;
            mid_at = boot_min >> 1;
        end
    end

    assign go = {s.rx_go, s.tx_go};

    // index 0 times transmit bits, index 1 times receive bits
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tmr
            hhu_bit_timer u_tmr (
                .clock(clock),
                .resetn(resetn),
                .ce(ce),
                .tick(s.tick),
                .restart(go[gi]),
                .len(bit_len),
                .mid_at(mid_at),
                .mid(mid[gi]),
                .fin(fin[gi])
            );
        end
    endgenerate

    always_comb begin
        logic rx_push;
        logic rx_pop;
        logic tx_push;
        logic tx_pop;
        logic [7:0] rx_byte;
        logic [7:0] acc_sum;
        acc_sum = {1'b0, s.acc} + {1'b0, (s.cfg.uclk_fast ? `HHU_UCLK_FAST_MHZ : `HHU_UCLK_SLOW_MHZ)};
        rx_push = 1'b0;
        rx_pop = 1'b0;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_byte = 8'h00;
        next_s = s;
        next_s.tx_go = 1'b0;
        next_s.rx_go = 1'b0;
        next_s.frame_err = 1'b0;

        // three stage pin sync; a level counts once stages two and three agree
        next_s.rx_sync = {s.rx_sync[1:0], rxd};
        next_s.cts_sync = {s.cts_sync[1:0], cts_n};
        if (s.rx_sync[1] == s.rx_sync[2]) begin
            next_s.rx_lvl = s.rx_sync[2];
        end
        if (s.cts_sync[1] == s.cts_sync[2]) begin
            next_s.cts_lvl = s.cts_sync[2];
        end

        // uart clock enable at 24 or 48 mhz drawn from the system clock
        // the sum is one bit wider: at 48 mhz it passes 127 before the wrap
        if (acc_sum >= {1'b0, `HHU_SYS_MHZ}) begin
            next_s.acc = 7'(acc_sum - {1'b0, `HHU_SYS_MHZ});
            next_s.tick = 1'b1;
        end else begin
            next_s.acc = acc_sum[6:0];
            next_s.tick = 1'b0;
        end

        // new rate takes effect at once; a frame in flight may be corrupted
        if (cfg_load) begin
            next_s.cfg = cfg_in;
        end

        // transmitter: starts a frame only while the host grants clear to send
        unique case (s.tx_st)
            HHU_TX_IDLE: begin
                if (s.tx_cnt != 11'h000 && !s.cts_lvl) begin
                    next_s.tx_sh = {1'b1, s.txq[s.tx_rd], 1'b0};
                    next_s.tx_bit = 4'h0;
                    next_s.tx_go = 1'b1;
                    next_s.tx_st = HHU_TX_SHIFT;
                    tx_pop = 1'b1;
                end
            end
            HHU_TX_SHIFT: begin
                if (fin[0]) begin
                    next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
                    next_s.tx_bit = s.tx_bit + 4'h1;
                    if (s.tx_bit == `HHU_FRAME_BITS) begin
                        next_s.tx_st = HHU_TX_IDLE;
                    end
                end
            end
        endcase
        next_s.txd = (next_s.tx_st == HHU_TX_SHIFT) ? next_s.tx_sh[0] : 1'b1;

        // receiver: start edge, then sample each bit at its stuffed midpoint
        unique case (s.rx_st)
            HHU_RX_IDLE: begin
                if (s.rx_lvl && !next_s.rx_lvl) begin
                    next_s.rx_go = 1'b1;
                    next_s.rx_bit = 4'h0;
                    next_s.rx_st = HHU_RX_BITS;
                end
            end
            HHU_RX_BITS: begin
                if (mid[1]) begin
                    next_s.rx_bit = s.rx_bit + 4'h1;
                    if (s.rx_bit == 4'h0 && s.rx_lvl) begin
                        next_s.rx_st = HHU_RX_IDLE; // false start glitch
                    end else if (s.rx_bit == `HHU_FRAME_BITS) begin
                        next_s.rx_st = HHU_RX_IDLE;
                        if (!s.rx_lvl) begin
                            next_s.frame_err = 1'b1;
                        end else if (s.rx_cnt != 11'(`HHU_QDEPTH)) begin
                            rx_push = 1'b1;
                            rx_byte = s.rx_sh;
                        end
                    end else if (s.rx_bit != 4'h0) begin
                        next_s.rx_sh = {s.rx_lvl, s.rx_sh[7:1]};
                    end
                end
            end
        endcase

        // receive queue with a one word output stage that holds under back pressure
        if (s.rx_cnt != 11'h000 && (!s.rx_valid || rx_ready)) begin
            rx_pop = 1'b1;
            next_s.rx_valid = 1'b1;
            next_s.rx_data = s.rxq[s.rx_rd];
            next_s.rx_rd = hhu_next_idx(s.rx_rd);
        end else if (rx_ready) begin
            next_s.rx_valid = 1'b0;
        end
        if (rx_push) begin
            next_s.rxq[s.rx_wr] = rx_byte;
            next_s.rx_wr = hhu_next_idx(s.rx_wr);
        end
        next_s.rx_cnt = s.rx_cnt + {10'h000, rx_push} - {10'h000, rx_pop};
        next_s.rts_n = (next_s.rx_cnt >= `HHU_RTS_LEVEL);

        // transmit queue fed by the host interface logic
        tx_push = tx_valid && s.tx_ready;
        if (tx_push) begin
            next_s.txq[s.tx_wr] = tx_data;
            next_s.tx_wr = hhu_next_idx(s.tx_wr);
        end
        if (tx_pop) begin
            next_s.tx_rd = hhu_next_idx(s.tx_rd);
        end
        next_s.tx_cnt = s.tx_cnt + {10'h000, tx_push} - {10'h000, tx_pop};
        next_s.tx_ready = (next_s.tx_cnt != 11'(`HHU_QDEPTH));
    end

    // reset leaves txd idle high, rts_n low and the rate at the default 115.2 kbaud
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.rx_sync <= 3'h7;
            s.cts_sync <= 3'h7;
            s.rx_lvl <= 1'b1;
            s.cts_lvl <= 1'b1;
            s.txd <= 1'b1;
            s.tx_ready <= 1'b1;
            s.cfg.baud_divisor_reg <= `HHU_DIV_RST;
            s.cfg.baud_adjust_reg <= `HHU_ADJ_RST;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign txd = s.txd;
    assign rts_n = s.rts_n;
    assign tx_ready = s.tx_ready;
    assign rx_valid = s.rx_valid;
    assign rx_data = s.rx_data;
    assign frame_err = s.frame_err;

    chk_rts_near_full: assert property (@(posedge clock) disable iff (!resetn)
        rts_n == (s.rx_cnt >= `HHU_RTS_LEVEL))
        else $error("rts does not follow the receive fill level");
    chk_cts_gates_tx: assert property (@(posedge clock) disable iff (!resetn)
        (ce && $rose(s.tx_st == HHU_TX_SHIFT)) |-> ($past(s.cts_lvl) == 1'b0 && s.tx_go))
        else $error("frame started without clear to send");
    chk_rxq_bound: assert property (@(posedge clock) disable iff (!resetn)
        s.rx_cnt <= 11'(`HHU_QDEPTH) && (s.rx_cnt != 11'h000 || s.rx_wr == s.rx_rd))
        else $error("receive queue count out of range");
    chk_txq_bound: assert property (@(posedge clock) disable iff (!resetn)
        (s.tx_cnt == 11'(`HHU_QDEPTH)) |-> !tx_ready)
        else $error("transmit queue offers room while full");
    chk_rate_load: assert property (@(posedge clock) disable iff (!resetn)
        (ce && cfg_load) |=> (s.cfg.baud_divisor_reg == $past(cfg_in.baud_divisor_reg)
            && s.cfg.baud_adjust_reg == $past(cfg_in.baud_adjust_reg)))
        else $error("rate command not applied");
    chk_div_by_16: assert property (@(posedge clock) disable iff (!resetn)
        (!s.cfg.high_rate && s.cfg.baud_divisor_reg != 8'h00) |-> (base[3:0] == 4'h0))
        else $error("normal mode bit time not a multiple of 16");
    chk_boot_cap: assert property (@(posedge clock) disable iff (!resetn)
        boot_active |-> (bit_len >= boot_min))
        else $error("bit time shorter than the boot cap");
    chk_stuff_bound: assert property (@(posedge clock) disable iff (!resetn)
        boot_active || (bit_len <= base + 13'h0010 && mid_at <= (base >> 1) + 13'h0008))
        else $error("stuffing beyond eight cycles per half");
    chk_tick_rate: assert property (@(posedge clock) disable iff (!resetn)
        (ce && s.tick) |=> (ce |-> !s.tick))
        else $error("uart clock enable faster than 48 mhz");
endmodule
`default_nettype wire

// ---- src/hhu_params.svh ----
/*
 * constants of the host uart: queue depth, reset rate settings,
 * stuffing limits, uart clock rates and the boot rate cap.
 * assumes a 100 mhz system clock feeding the block.
 */
`ifndef HHU_PARAMS_SVH
`define HHU_PARAMS_SVH

`define HHU_SYS_MHZ 7'd100
`define HHU_UCLK_SLOW_MHZ 7'd24
`define HHU_UCLK_FAST_MHZ 7'd48
`define HHU_QDEPTH 1040
`define HHU_QIDX_LAST 11'h40f
`define HHU_RTS_LEVEL 11'h400
`define HHU_DIV_RST 8'h0d
`define HHU_ADJ_RST 8'h00
`define HHU_OVS_SHIFT 4
`define HHU_STUFF_MAX 4'h8
`define HHU_MIN_BIT 13'h002
`define HHU_BOOT_KBPS 750
`define HHU_BOOT_BIT_SLOW 13'((24000 + `HHU_BOOT_KBPS - 1) / `HHU_BOOT_KBPS)
`define HHU_BOOT_BIT_FAST 13'((48000 + `HHU_BOOT_KBPS - 1) / `HHU_BOOT_KBPS)
`define HHU_FRAME_BITS 4'h9

`endif

// ---- src/hhu_pkg.sv ----
/*
 * types of the host uart: rate settings, state of the bit timer and
 * state of the main block.
 * assumes hhu_params.svh is on the include path.
 */
`include "hhu_params.svh"
`default_nettype none
package hhu_pkg;
    // rate settings as loaded by the vendor rate command
    typedef struct packed {
        logic high_rate;
        logic uclk_fast;
        logic [7:0] baud_divisor_reg;
        logic [7:0] baud_adjust_reg;
    } hhu_cfg_t;

    typedef enum logic {HHU_TX_IDLE, HHU_TX_SHIFT} hhu_tx_st_t;
    typedef enum logic {HHU_RX_IDLE, HHU_RX_BITS} hhu_rx_st_t;

    typedef struct packed {
        logic [12:0] cnt;
        logic mid;
        logic fin;
    } hhu_tmr_t;

    typedef struct packed {
        logic [2:0] rx_sync;
        logic [2:0] cts_sync;
        logic rx_lvl;
        logic cts_lvl;
        hhu_cfg_t cfg;
        logic [6:0] acc;
        logic tick;
        logic [`HHU_QDEPTH-1:0][7:0] rxq;
        logic [10:0] rx_wr;
        logic [10:0] rx_rd;
        logic [10:0] rx_cnt;
        logic [`HHU_QDEPTH-1:0][7:0] txq;
        logic [10:0] tx_wr;
        logic [10:0] tx_rd;
        logic [10:0] tx_cnt;
        hhu_tx_st_t tx_st;
        logic [9:0] tx_sh;
        logic [3:0] tx_bit;
        logic tx_go;
        hhu_rx_st_t rx_st;
        logic [7:0] rx_sh;
        logic [3:0] rx_bit;
        logic rx_go;
        logic txd;
        logic rts_n;
        logic tx_ready;
        logic rx_valid;
        logic [7:0] rx_data;
        logic frame_err;
    } hhu_state_t;
endpackage
`default_nettype wire

// ---- src/hhu_bit_timer.sv ----
/*
 * bit timer: counts uart clock ticks through one bit time and pulses
 * at the sampling point and at the end of the bit.
 * assumes len is at least two and mid_at lies below len.
 */
`default_nettype none
module hhu_bit_timer
    import hhu_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    input wire logic tick,
    input wire logic restart,
    input wire logic [12:0] len,
    input wire logic [12:0] mid_at,
    output logic mid,
    output logic fin
);
    hhu_tmr_t s;
    hhu_tmr_t next_s;

    // restart wins over a tick so a new frame always starts at zero
    always_comb begin
        next_s = s;
        next_s.mid = 1'b0;
        next_s.fin = 1'b0;
        if (restart) begin
            next_s.cnt = 13'h0000;
        end else if (tick) begin
            // fire on the tick that reaches the sample point; pin sync and start detect already eat into the bit
            if (s.cnt + 13'h0001 == mid_at) begin
                next_s.mid = 1'b1;
            end
            if (s.cnt >= len - 13'h0001) begin
                next_s.cnt = 13'h0000;
                next_s.fin = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 13'h0001;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign mid = s.mid;
    assign fin = s.fin;

    chk_end_wraps: assert property (@(posedge clock) disable iff (!resetn)
        (ce && tick && !restart && s.cnt >= len - 13'h0001) |=> (fin && s.cnt == 13'h0000))
        else $error("bit timer did not wrap at the end of the bit");
endmodule
`default_nettype wire

// ---- testbench/hhu_host_model.sv ----
/*
 * host side model of the four wire link: sends 8n1 frames toward the
 * device and captures the device's frames from its transmit line.
 * assumes the bench sets bit_ns to the bit time in force and uses stall
 * to hold the device's transmitter.
 */
`default_nettype none
module hhu_host_model (
    input wire logic txd,
    input wire logic rts_n,
    output logic rxd,
    output logic cts_n
);
    timeunit 1ns;
    timeprecision 1ps;
    real bit_ns = 8666.7;
    logic stall = 1'b0;
    logic [7:0] got[$];

    // clear to send follows stall; the link idles high
    assign cts_n = stall;
    initial rxd = 1'b1;

    // one frame, lsb first at the exact nominal rate; waits while the device asks us to stop
    task automatic send(input logic [7:0] b, input logic bad_stop);
        while (rts_n !== 1'b0) #(bit_ns);
        rxd = 1'b0;
        #(bit_ns);
        for (int i = 0; i < 8; i++) begin
            rxd = b[i];
            #(bit_ns);
        end
        rxd = ~bad_stop;
        #(bit_ns);
        rxd = 1'b1;
    endtask

    // capture: sample each data bit at its centre, counted from the start edge
    initial begin
        logic [7:0] b;
        forever begin
            @(negedge txd);
            #(bit_ns * 1.5);
            for (int i = 0; i < 8; i++) begin
                b[i] = txd;
                #(bit_ns);
            end
            got.push_back(b);
        end
    end
endmodule
`default_nettype wire

// ---- testbench/hhu_host_uart_bench.sv ----
/*
 * bench for the host uart: bit time table, traffic both ways, flow
 * control, queue fill, frame error and reset in mid frame.
 * assumes hhu_host_model drives the far side of the serial pins.
 */
`include "hhu_params.svh"
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module hhu_host_uart_bench
    import hhu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, resetn, ce, rxd, cts_n, txd, rts_n, boot_active, cfg_load;
    logic tx_valid, tx_ready, rx_valid, rx_ready, frame_err;
    logic [7:0] tx_data, rx_data, b;
    hhu_cfg_t cfg_in;
    hhu_cfg_t cases [7] = '{18'h30800, 18'h30888, 18'h308ff, 18'h10131, 18'h208f8, 18'h30800, 18'h20200};
    logic [6:0] boots = 7'b1100000;
    int fail_count = 0, checked = 0, ferr = 0, n;
    int seed = 32'h7fe9894c;
    logic [7:0] got_rx[$], exp[$];

    hhu_host_uart u_hhu_host_uart (.clock(clock), .resetn(resetn), .ce(ce), .rxd(rxd), .cts_n(cts_n),
        .txd(txd), .rts_n(rts_n), .boot_active(boot_active), .cfg_load(cfg_load), .cfg_in(cfg_in),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .frame_err(frame_err));
    hhu_host_model u_hhu_host_model (.txd(txd), .rts_n(rts_n), .rxd(rxd), .cts_n(cts_n));

    function automatic int mhz(hhu_cfg_t c);
        return c.uclk_fast ? 48 : 24;
    endfunction

    // expected bit time in uart clocks: base, both stuffs clamped to eight, boot floor
    function automatic int ticks(hhu_cfg_t c, logic boot);
        int t;
        t = c.high_rate ? c.baud_divisor_reg : c.baud_divisor_reg * 16;
        if (t < 2) t = 2;
        t += (c.baud_adjust_reg[7:4] > 8) ? 8 : c.baud_adjust_reg[7:4];
        t += (c.baud_adjust_reg[3:0] > 8) ? 8 : c.baud_adjust_reg[3:0];
        if (boot && t < (c.uclk_fast ? `HHU_BOOT_BIT_FAST : `HHU_BOOT_BIT_SLOW)) begin
            t = c.uclk_fast ? `HHU_BOOT_BIT_FAST : `HHU_BOOT_BIT_SLOW;
        end
        return t;
    endfunction

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // receive side consumer and frame error counter
    always @(posedge clock) begin
        if ($sampled(rx_valid) === 1'b1 && $sampled(rx_ready) === 1'b1) got_rx.push_back($sampled(rx_data));
        if ($sampled(frame_err) === 1'b1) ferr++;
    end

    task automatic close_out();
        $display("%0d checks, %0d mismatches", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic end_test(input string nm);
        $display("test %s done, %0d mismatches so far", nm, fail_count);
    endtask

    // offers one byte and holds it until taken; valid stays up for back to back use
    task automatic push(input logic [7:0] v);
        @(negedge clock);
        tx_valid = 1'b1;
        tx_data = v;
        // ready is looked at while settled; the byte goes in at the following rising edge
        for (int i = 0; i < 5000 && tx_ready !== 1'b1; i++) @(negedge clock);
        @(posedge clock);
    endtask

    task automatic load(input hhu_cfg_t c, input logic boot);
        @(negedge clock);
        cfg_in = c;
        cfg_load = 1'b1;
        boot_active = boot;
        @(negedge clock);
        cfg_load = 1'b0;
        u_hhu_host_model.bit_ns = ticks(c, boot) * 1000.0 / mhz(c);
    endtask

    // sends 0xff so only the start bit is low, and times it in system clocks
    task automatic bit_len(input int t, input int f, input logic full);
        int k, e;
        k = 0;
        // restart and end registers add two cycles, the tick phase takes back up to one
        e = t * 100 / f + 1;
        push(8'hff);
        @(negedge clock);
        tx_valid = 1'b0;
        for (int i = 0; i < 3000 && txd !== 1'b0; i++) @(negedge clock);
        while (txd === 1'b0 && k < 3000) begin
            @(negedge clock);
            k++;
        end
        `CHK("start bit length", 1'b1, 1'((k >= e - 2) && (k <= e + 2)))
        if (full) begin
            repeat (11 * e) @(posedge clock);
            b = (u_hhu_host_model.got.size() > 0) ? u_hhu_host_model.got.pop_front() : 8'h00;
            `CHK("host byte", 8'hff, b)
        end
    endtask

    task automatic cmp_q(ref logic [7:0] q[$]);
        `CHK("byte count", exp.size(), q.size())
        for (int i = 0; i < exp.size() && i < q.size(); i++) `CHK("byte", exp[i], q[i])
        exp.delete();
        q.delete();
    endtask

    // hang guard, well beyond the longest expected run
    initial begin
        #1500000;
        fail_count++;
        close_out();
    end

    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        boot_active = 1'b0;
        cfg_load = 1'b0;
        cfg_in = '0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        rx_ready = 1'b0;
        repeat (12) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        `CHK("reset outputs", 5'b10100, {txd, rts_n, tx_ready, rx_valid, frame_err})
        bit_len(ticks({1'b0, 1'b0, `HHU_DIV_RST, `HHU_ADJ_RST}, 1'b0), 24, 1'b0);
        @(negedge clock);
        resetn = 1'b0;
        repeat (3) @(negedge clock);
        `CHK("txd in reset", 1'b1, txd)
        resetn = 1'b1;
        end_test("default rate");
        // fill the receive queue with nobody reading; the host stops when rts rises
        load({1'b1, 1'b1, 8'h04, 8'h00}, 1'b0);
        n = 0;
        while (rts_n === 1'b0 && n < 1040) begin
            exp.push_back(8'($random(seed)));
            u_hhu_host_model.send(exp[n], 1'b0);
            repeat (3) @(negedge clock);
            n++;
            if (n == 1000) `CHK("rts open", 1'b0, rts_n)
        end
        `CHK("rts threshold", 1'b1, 1'(n == 1024 || n == 1025))
        rx_ready = 1'b1;
        repeat (1100) @(negedge clock);
        `CHK("rts reopens", 1'b0, rts_n)
        cmp_q(got_rx);
        end_test("receive fill");
        u_hhu_host_model.got.delete();
        for (int k = 0; k < 7; k++) begin
            load(cases[k], boots[k]);
            bit_len(ticks(cases[k], boots[k]), mhz(cases[k]), 1'b1);
        end
        end_test("bit time table");
        load({1'b1, 1'b1, 8'h08, 8'h00}, 1'b0);
        for (int i = 0; i < 8; i++) begin
            b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? 8'h55 : 8'($random(seed));
            exp.push_back(b);
            push(b);
        end
        @(negedge clock);
        tx_valid = 1'b0;
        for (int i = 0; i < 20000 && u_hhu_host_model.got.size() < 8; i++) @(posedge clock);
        cmp_q(u_hhu_host_model.got);
        u_hhu_host_model.stall = 1'b1;
        repeat (5) @(negedge clock);
        exp.push_back(8'ha5);
        push(8'ha5);
        @(negedge clock);
        tx_valid = 1'b0;
        n = 0;
        repeat (400) @(negedge clock) if (txd === 1'b0) n++;
        `CHK("held by cts", 0, n)
        u_hhu_host_model.stall = 1'b0;
        for (int i = 0; i < 5000 && u_hhu_host_model.got.size() < 1; i++) @(posedge clock);
        cmp_q(u_hhu_host_model.got);
        end_test("transmit and flow");
        ferr = 0;
        u_hhu_host_model.send(8'h3c, 1'b1);
        repeat (20) @(negedge clock);
        `CHK("frame error pulse", 1, ferr)
        `CHK("bad byte dropped", 0, got_rx.size())
        exp.push_back(8'hc3);
        u_hhu_host_model.send(8'hc3, 1'b0);
        repeat (20) @(negedge clock);
        cmp_q(got_rx);
        end_test("frame error");
        // transmit queue fills while the host stalls
        u_hhu_host_model.stall = 1'b1;
        repeat (5) @(negedge clock);
        n = 0;
        tx_valid = 1'b1;
        for (int i = 0; i < 1045; i++) begin
            if (tx_ready === 1'b1) n++;
            @(negedge clock);
            tx_data = 8'(i);
        end
        tx_valid = 1'b0;
        `CHK("tx queue depth", `HHU_QDEPTH, n)
        `CHK("tx full", 1'b0, tx_ready)
        resetn = 1'b0;
        @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        `CHK("tx after reset", 1'b1, tx_ready)
        end_test("transmit fill");
        close_out();
    end
endmodule
`default_nettype wire
